//--- hmp_device.sv
// device end of the host memory port: on-chip program and data memory
// reached by an asynchronous host over a multiplexed 16-bit bus
// assumes: host strobes and bus come from another clock domain
//
// Notes on behaviour
// - host reads/writes memory, one cycle overhead
// - control register area never written by host
// - top bit set: low byte selects overlay
// - top bit clear: address plus memory space
// - software keeps overlay fields at zero
// - host checks acknowledge before each access
// - 16-bit multiplexed bus, 24-bit program words
// - strobes asynchronous, core keeps running
// - address increments after every data-space transaction, after every second program-space one
// - host drives address and space at latch
// - latch on strobe fall or select rise
// - one sync cycle, one memory cycle
// - latched address never readable by host
// - core sets start address via control word
// - system bit selects short read timing
// - mode pins 1,0,1 boot through port
// - execution held until program word zero written
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
module hmp_device #(
    parameter int ADDR_W = hmp_pkg::ADDR_W
) (
    // clock and reset
    input  wire logic                 clk_i,
    input  wire logic                 rstn_i,
    // host link
    hmp_link_if.dev                   link,
    // boot straps
    input  wire logic                 mode_a_i,
    input  wire logic                 mode_b_i,
    input  wire logic                 mode_c_i,
    // core register access
    input  wire logic                 core_we_i,
    input  wire logic [ADDR_W-1:0]    core_addr_i,
    input  wire logic [15:0]          core_wdata_i,
    output logic      [15:0]          core_rdata_o,
    // status
    output logic      [7:0]           overlay_o,
    output logic                      hold_exec_o
);
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SYNC,
        ST_ACCESS,
        ST_DONE
    } hmp_state_type;

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    // packed as {sel_n, ale, rd_n, wr_n, bus}
    logic [19:0]   meta_q;
    logic [19:0]   sync_q;
    logic [19:0]   prev_q;
    logic [2:0]    mode_meta_q;
    logic [2:0]    mode_sync_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q      <= 20'hb_ffff;
            sync_q      <= 20'hb_ffff;
            prev_q      <= 20'hb_ffff;
            mode_meta_q <= 3'h0;
            mode_sync_q <= 3'h0;
        end else begin
            meta_q      <= {link.port_select_n, link.address_latch_strobe, link.port_read_strobe_n,
                            link.port_write_strobe_n, link.host_addr_data_bus};
            sync_q      <= meta_q;
            prev_q      <= sync_q;
            mode_meta_q <= {mode_c_i, mode_b_i, mode_a_i};
            mode_sync_q <= mode_meta_q;
        end
    end

    logic          sel_n_s;
    logic          ale_s;
    logic          rd_n_s;
    logic          wr_n_s;
    logic [15:0]   bus_s;
    logic          latch_ev;
    logic          req_ev;

    assign sel_n_s  = sync_q[19];
    assign ale_s    = sync_q[18];
    assign rd_n_s   = sync_q[17];
    assign wr_n_s   = sync_q[16];
    assign bus_s    = sync_q[15:0];
    // host releases the bus with the strobe, so the latch takes the word from the stage before the fall
    assign latch_ev = prev_q[18] && !prev_q[19] && (!ale_s || sel_n_s);
    assign req_ev   = !sel_n_s && (!rd_n_s || !wr_n_s);

    // ------------------------------------------------------------
    // access sequencer
    // ------------------------------------------------------------
    hmp_state_type state_q;
    logic          is_wr_q;
    logic [15:0]   wdata_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_q <= ST_IDLE;
            is_wr_q <= 1'b0;
            wdata_q <= 16'h0000;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    if (req_ev) begin
                        state_q <= ST_SYNC;
                        is_wr_q <= !wr_n_s;
                        wdata_q <= bus_s;
                    end
                end
                ST_SYNC: begin
                    state_q <= ST_ACCESS;
                end
                ST_ACCESS: begin
                    state_q <= ST_DONE;
                end
                ST_DONE: begin
                    // wait for strobe release so one strobe means one access
                    if (sel_n_s || (rd_n_s && wr_n_s)) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    assign link.port_acknowledge_n = (state_q == ST_SYNC) || (state_q == ST_ACCESS);

    // ------------------------------------------------------------
    // address latch and control registers
    // ------------------------------------------------------------
    logic [ADDR_W-1:0] addr_q;
    logic              space_prog_q;
    logic              half_q;
    logic [7:0]        overlay_q;
    logic              short_rd_q;
    logic              ctl_wr;
    logic [15:0]       ctl_word;
    logic              mem_step;
    logic              data_ok;

    // a host latch wins over a core write in the same cycle
    assign ctl_wr   = latch_ev || (core_we_i && core_addr_i == hmp_pkg::OVERLAY_ADDR);
    assign ctl_word = latch_ev ? prev_q[15:0] : core_wdata_i;
    assign mem_step = (state_q == ST_ACCESS);
    assign data_ok  = addr_q < hmp_pkg::DATA_REG_BASE;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            addr_q     <= '0;
            space_prog_q <= 1'b0;
            half_q     <= 1'b0;
            overlay_q  <= hmp_pkg::OVERLAY_RST;
        end else if (ctl_wr) begin
            if (ctl_word[hmp_pkg::CTL_SEL_BIT]) begin
                overlay_q <= ctl_word[7:0];
            end else begin
                addr_q     <= ctl_word[ADDR_W-1:0];
                space_prog_q <= ctl_word[hmp_pkg::SPACE_BIT];
                half_q     <= 1'b0;
            end
        end else if (mem_step) begin
            if (space_prog_q) begin
                half_q <= !half_q;
                if (half_q) begin
                    addr_q <= addr_q + 1'b1;
                end
            end else begin
                addr_q <= addr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            short_rd_q <= hmp_pkg::SHORT_RD_RST;
        end else if (core_we_i && core_addr_i == hmp_pkg::SYSCTL_ADDR) begin
            short_rd_q <= core_wdata_i[hmp_pkg::SHORT_RD_BIT];
        end
    end

    // the latched address has no read path at all
    always_comb begin
        core_rdata_o = 16'h0000;
        if (core_addr_i == hmp_pkg::OVERLAY_ADDR) begin
            core_rdata_o = {8'h00, overlay_q};
        end else if (core_addr_i == hmp_pkg::SYSCTL_ADDR) begin
            core_rdata_o[hmp_pkg::SHORT_RD_BIT] = short_rd_q;
        end
    end

    assign overlay_o = overlay_q;

    // ------------------------------------------------------------
    // memories
    // ------------------------------------------------------------
    logic [hmp_pkg::PROG_W-1:0] prog_mem [2**ADDR_W];
    logic [hmp_pkg::DATA_W-1:0] data_mem [2**ADDR_W];
    logic [15:0]                prog_hi_q;
    logic [15:0]                rdata_q;

    always_ff @(posedge clk_i) begin
        if (mem_step && is_wr_q && space_prog_q && half_q) begin
            prog_mem[addr_q] <= {prog_hi_q, wdata_q[7:0]};
        end
        if (mem_step && is_wr_q && !space_prog_q && data_ok) begin
            data_mem[addr_q] <= wdata_q;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            prog_hi_q <= 16'h0000;
            rdata_q   <= 16'h0000;
        end else if (mem_step) begin
            if (is_wr_q) begin
                prog_hi_q <= wdata_q;
            end else if (space_prog_q) begin
                rdata_q <= half_q ? {8'h00, prog_mem[addr_q][7:0]} : prog_mem[addr_q][23:8];
            end else begin
                rdata_q <= data_ok ? data_mem[addr_q] : 16'h0000;
            end
        end
    end

    // ------------------------------------------------------------
    // read drive
    // ------------------------------------------------------------
    // short-read mode drives early with the last word; normal mode only once fresh
    logic rd_active;
    logic dev_oe_q;

    assign rd_active = !sel_n_s && !rd_n_s && !is_wr_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            dev_oe_q <= 1'b0;
        end else begin
            dev_oe_q <= rd_active && (state_q == ST_ACCESS || state_q == ST_DONE
                                      || (short_rd_q && state_q != ST_IDLE));
        end
    end

    assign link.dev_bus_oe  = dev_oe_q;
    assign link.dev_bus_out = rdata_q;

    // ------------------------------------------------------------
    // boot through the port
    // ------------------------------------------------------------
    logic [2:0] age_q;
    logic       boot_wait_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            age_q       <= 3'h0;
            boot_wait_q <= 1'b0;
        end else begin
            age_q <= {age_q[1:0], 1'b1};
            if (age_q == hmp_pkg::STRAP_READY) begin
                boot_wait_q <= (mode_sync_q == hmp_pkg::BOOT_HOST_MODE);
            end else if (mem_step && is_wr_q && space_prog_q && half_q && addr_q == '0) begin
                boot_wait_q <= 1'b0;
            end
        end
    end

    // held from reset until the straps are sampled, so the core cannot slip ahead
    assign hold_exec_o = boot_wait_q || (age_q != 3'h7);
endmodule

//--- hmp_pkg.sv
// package for the host memory port: register map, bit fields, timing counts
// assumes nothing beyond a SystemVerilog compiler
package hmp_pkg;
    // ------------------------------------------------------------
    // device side
    // ------------------------------------------------------------
    localparam int          ADDR_W         = 14;
    localparam int          DATA_W         = 16;
    localparam int          PROG_W         = 24;
    localparam int          OVL_W          = 8;
    localparam logic [13:0] OVERLAY_ADDR   = 14'h3fe0;
    localparam logic [13:0] SYSCTL_ADDR    = 14'h3fe7;
    localparam logic [13:0] DATA_REG_BASE  = 14'h3fe0;
    localparam int          CTL_SEL_BIT    = 15;
    localparam int          SPACE_BIT      = 14;
    localparam int          SHORT_RD_BIT   = 14;
    localparam logic [2:0]  BOOT_HOST_MODE = 3'h5;
    localparam logic [2:0]  STRAP_READY    = 3'h3;
    localparam logic        SHORT_RD_RST   = 1'b0;
    localparam logic [7:0]  OVERLAY_RST    = 8'h00;
    // ------------------------------------------------------------
    // host side
    // ------------------------------------------------------------
    localparam logic [3:0]  CMD_OFF        = 4'h0;
    localparam logic [3:0]  STATUS_OFF     = 4'h4;
    localparam logic [3:0]  RDATA_OFF      = 4'h8;
    localparam int          KIND_LSB       = 16;
    localparam int          ALE_CYC        = 4;
    localparam int          GAP_CYC        = 4;
    typedef enum logic [1:0] {
        HMP_LATCH,
        HMP_WRITE,
        HMP_READ,
        HMP_NONE
    } hmp_kind_type;
endpackage

//--- hmp_link_if.sv
// interface joining the host end and the device end of the port
// assumes the bench resolves nothing else: the shared bus is formed here
`timescale 1ns/1ps
interface hmp_link_if;
    logic        port_select_n;
    logic        address_latch_strobe;
    logic        port_read_strobe_n;
    logic        port_write_strobe_n;
    logic        port_acknowledge_n;
    logic [15:0] host_bus_out;
    logic        host_bus_oe;
    logic [15:0] dev_bus_out;
    logic        dev_bus_oe;
    logic [15:0] host_addr_data_bus;

    // an undriven bus reads as pulled high
    assign host_addr_data_bus = dev_bus_oe ? dev_bus_out : (host_bus_oe ? host_bus_out : 16'hffff);

    modport dev (
        input  port_select_n,
        input  address_latch_strobe,
        input  port_read_strobe_n,
        input  port_write_strobe_n,
        input  host_addr_data_bus,
        output port_acknowledge_n,
        output dev_bus_out,
        output dev_bus_oe
    );
    modport host (
        output port_select_n,
        output address_latch_strobe,
        output port_read_strobe_n,
        output port_write_strobe_n,
        output host_bus_out,
        output host_bus_oe,
        input  port_acknowledge_n,
        input  host_addr_data_bus
    );
endinterface

//--- hmp_host.sv
// host end of the host memory port, run by software over AXI4-Lite
// assumes: one AXI4-Lite master; device acknowledge and bus are asynchronous
`timescale 1ns/1ps
module hmp_host (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // device link
    hmp_link_if.host         link,
    // axi4-lite write
    input  wire logic [3:0]  s_axi_awaddr_i,
    input  wire logic        s_axi_awvalid_i,
    output logic             s_axi_awready_o,
    input  wire logic [31:0] s_axi_wdata_i,
    input  wire logic [3:0]  s_axi_wstrb_i,
    input  wire logic        s_axi_wvalid_i,
    output logic             s_axi_wready_o,
    output logic [1:0]       s_axi_bresp_o,
    output logic             s_axi_bvalid_o,
    input  wire logic        s_axi_bready_i,
    // axi4-lite read
    input  wire logic [3:0]  s_axi_araddr_i,
    input  wire logic        s_axi_arvalid_i,
    output logic             s_axi_arready_o,
    output logic [31:0]      s_axi_rdata_o,
    output logic [1:0]       s_axi_rresp_o,
    output logic             s_axi_rvalid_o,
    input  wire logic        s_axi_rready_i
);
    typedef enum logic [2:0] {
        H_IDLE,
        H_WAIT,
        H_STROBE,
        H_BUSY,
        H_GAP
    } hmp_hstate_type;

    // ------------------------------------------------------------
    // register slave
    // ------------------------------------------------------------
    hmp_hstate_type         st_q;
    hmp_pkg::hmp_kind_type  kind_q;
    logic [15:0]            cmd_q;
    logic [15:0]            rd_q;
    logic                   bvalid_q;
    logic                   rvalid_q;
    logic [31:0]            rdata_q;
    logic                   wr_take;
    logic                   go;

    // address and data are taken together; a lone channel waits for its partner
    assign wr_take         = s_axi_awvalid_i && s_axi_wvalid_i && !bvalid_q;
    assign s_axi_awready_o = wr_take;
    assign s_axi_wready_o  = wr_take;
    assign s_axi_bvalid_o  = bvalid_q;
    assign s_axi_bresp_o   = 2'h0;
    assign s_axi_arready_o = !rvalid_q;
    assign s_axi_rvalid_o  = rvalid_q;
    assign s_axi_rdata_o   = rdata_q;
    assign s_axi_rresp_o   = 2'h0;
    // a command written while busy is dropped
    assign go = wr_take && s_axi_awaddr_i == hmp_pkg::CMD_OFF && st_q == H_IDLE && s_axi_wstrb_i[2:0] == 3'h7;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            bvalid_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
        end else begin
            if (wr_take) begin
                bvalid_q <= 1'b1;
            end else if (s_axi_bready_i) begin
                bvalid_q <= 1'b0;
            end
            if (s_axi_arvalid_i && !rvalid_q) begin
                rvalid_q <= 1'b1;
                unique case (s_axi_araddr_i)
                    hmp_pkg::STATUS_OFF: rdata_q <= {31'h0000_0000, st_q != H_IDLE};
                    hmp_pkg::RDATA_OFF:  rdata_q <= {16'h0000, rd_q};
                    default:             rdata_q <= 32'h0000_0000;
                endcase
            end else if (s_axi_rready_i) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // link sequencer
    // ------------------------------------------------------------
    logic [16:0] meta_q;
    logic [16:0] sync_q;
    logic        ack_n_s;
    logic [3:0]  cnt_q;
    logic        sel_n_q;
    logic        ale_q;
    logic        rd_n_q;
    logic        wr_n_q;
    logic        oe_q;

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            meta_q <= 17'h1_0000;
            sync_q <= 17'h1_0000;
        end else begin
            meta_q <= {link.port_acknowledge_n, link.host_addr_data_bus};
            sync_q <= meta_q;
        end
    end

    assign ack_n_s = sync_q[16];

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            st_q    <= H_IDLE;
            kind_q  <= hmp_pkg::HMP_NONE;
            cmd_q   <= 16'h0000;
            rd_q    <= 16'h0000;
            cnt_q   <= 4'h0;
            sel_n_q <= 1'b1;
            ale_q   <= 1'b0;
            rd_n_q  <= 1'b1;
            wr_n_q  <= 1'b1;
            oe_q    <= 1'b0;
        end else begin
            unique case (st_q)
                H_IDLE: begin
                    if (go) begin
                        st_q   <= H_WAIT;
                        kind_q <= hmp_pkg::hmp_kind_type'(s_axi_wdata_i[hmp_pkg::KIND_LSB +: 2]);
                        cmd_q  <= s_axi_wdata_i[15:0];
                    end
                end
                H_WAIT: begin
                    if (!ack_n_s) begin
                        st_q    <= H_STROBE;
                        cnt_q   <= 4'h0;
                        sel_n_q <= 1'b0;
                        ale_q   <= kind_q == hmp_pkg::HMP_LATCH;
                        rd_n_q  <= kind_q != hmp_pkg::HMP_READ;
                        wr_n_q  <= kind_q != hmp_pkg::HMP_WRITE;
                        oe_q    <= kind_q != hmp_pkg::HMP_READ;
                    end
                end
                H_STROBE: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (kind_q == hmp_pkg::HMP_LATCH || kind_q == hmp_pkg::HMP_NONE) begin
                        if (cnt_q == 4'(hmp_pkg::ALE_CYC - 1)) begin
                            st_q    <= H_GAP;
                            cnt_q   <= 4'h0;
                            sel_n_q <= 1'b1;
                            ale_q   <= 1'b0;
                            oe_q    <= 1'b0;
                        end
                    end else if (ack_n_s) begin
                        st_q <= H_BUSY;
                    end
                end
                H_BUSY: begin
                    if (!ack_n_s) begin
                        if (kind_q == hmp_pkg::HMP_READ) begin
                            rd_q <= sync_q[15:0];
                        end
                        st_q    <= H_GAP;
                        cnt_q   <= 4'h0;
                        sel_n_q <= 1'b1;
                        rd_n_q  <= 1'b1;
                        wr_n_q  <= 1'b1;
                        oe_q    <= 1'b0;
                    end
                end
                H_GAP: begin
                    // lets the device see the release before the next strobe
                    cnt_q <= cnt_q + 1'b1;
                    if (cnt_q == 4'(hmp_pkg::GAP_CYC - 1)) begin
                        st_q <= H_IDLE;
                    end
                end
                default: begin
                    st_q <= H_IDLE;
                end
            endcase
        end
    end

    assign link.port_select_n        = sel_n_q;
    assign link.address_latch_strobe = ale_q;
    assign link.port_read_strobe_n   = rd_n_q;
    assign link.port_write_strobe_n  = wr_n_q;
    assign link.host_bus_out         = cmd_q;
    assign link.host_bus_oe          = oe_q;
endmodule

//--- hmp_assertions.sv
// checker for the link between the host end and the device end
// assumes the bench wires it to the link signals by name
`timescale 1ns/1ps
module hmp_assertions (
    // clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // link
    input wire logic port_select_n,
    input wire logic address_latch_strobe,
    input wire logic port_read_strobe_n,
    input wire logic port_write_strobe_n,
    input wire logic port_acknowledge_n,
    input wire logic host_bus_oe,
    input wire logic dev_bus_oe
);
    // ----------------------------------------
    // link timing
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire logic acc = !port_select_n && !(port_read_strobe_n && port_write_strobe_n);
    // busy spans the sync cycle and the memory cycle
    sequence s_busy2;
        port_acknowledge_n ##1 port_acknowledge_n;
    endsequence
    a_busy_after_strobe: assert property ($rose(acc) |-> ##[1:4] s_busy2)
        else $error("no busy after strobe");
    a_busy_two_cycles: assert property ($rose(port_acknowledge_n) |-> s_busy2 ##1 !port_acknowledge_n)
        else $error("busy not two cycles");
    a_busy_has_cause: assert property ($rose(port_acknowledge_n) |-> $past(acc, 3) && $past(acc))
        else $error("busy without strobe");
    a_ready_holds: assert property ($fell(port_acknowledge_n) |-> !port_acknowledge_n [*4])
        else $error("ready dropped early");
    a_no_contention: assert property (!(dev_bus_oe && host_bus_oe))
        else $error("both ends drive bus");
    a_drive_on_read: assert property ($rose(dev_bus_oe) |-> !port_read_strobe_n && !port_select_n)
        else $error("drive without read");
    a_drive_held: assert property (dev_bus_oe && acc && !port_read_strobe_n |=> dev_bus_oe)
        else $error("drive dropped in read");
    a_latch_width: assert property ($rose(address_latch_strobe) |-> address_latch_strobe [*4] ##1 !address_latch_strobe)
        else $error("latch strobe width");
    a_latch_driven: assert property ($rose(address_latch_strobe) |-> !port_select_n && host_bus_oe)
        else $error("latch without select");
    a_strobe_ready: assert property ($fell(port_select_n) |-> !port_acknowledge_n)
        else $error("strobe while busy");
endmodule

//--- test_hmp.sv
// self-checking bench: host end and device end joined by the link
// assumes package and link interface are compiled first
`timescale 1ns/1ps
module test_hmp;
    logic        clk_i = 1'b0;
    logic        rstn_i = 1'b0;
    logic [3:0]  awaddr = 4'h0, araddr = 4'h0;
    logic        awv = 1'b0, wv = 1'b0, brdy = 1'b0, arv = 1'b0, rrdy = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic        awr, wrd, bv, arr, rv, hold, we = 1'b0;
    logic [31:0] rdata;
    logic [13:0] caddr = hmp_pkg::OVERLAY_ADDR;
    logic [15:0] cwd = 16'h0000, crd;
    logic [7:0]  ovl;
    int          errors = 0, compares = 0;
    hmp_link_if link ();
    // straps ask for boot through the port
    hmp_device i_hmp_device (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .mode_a_i(1'b1),
        .mode_b_i(1'b0), .mode_c_i(1'b1), .core_we_i(we), .core_addr_i(caddr), .core_wdata_i(cwd),
        .core_rdata_o(crd), .overlay_o(ovl), .hold_exec_o(hold));
    hmp_host i_hmp_host (.clk_i(clk_i), .rstn_i(rstn_i), .link(link), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
        .s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_bresp_o(), .s_axi_bvalid_o(bv),
        .s_axi_bready_i(brdy), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(), .s_axi_rvalid_o(rv), .s_axi_rready_i(rrdy));
    hmp_assertions i_hmp_assertions (.clk_i(clk_i), .rstn_i(rstn_i), .port_select_n(link.port_select_n),
        .address_latch_strobe(link.address_latch_strobe), .port_read_strobe_n(link.port_read_strobe_n),
        .port_write_strobe_n(link.port_write_strobe_n), .port_acknowledge_n(link.port_acknowledge_n),
        .host_bus_oe(link.host_bus_oe), .dev_bus_oe(link.dev_bus_oe));
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    // ready is looked at mid-cycle, where the combinational answer has settled
    task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
        logic aw_t, w_t, b_t;
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        do begin
            @(negedge clk_i);
            aw_t = awv && awr;
            w_t = wv && wrd;
            b_t = bv;
            @(posedge clk_i);
            if (aw_t) awv <= 1'b0;
            if (w_t) wv <= 1'b0;
        end while (!b_t);
    endtask
    task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
        logic ar_t, r_t;
        araddr <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(negedge clk_i);
            ar_t = arv && arr;
            r_t = rv;
            d = rdata;
            @(posedge clk_i);
            if (ar_t) arv <= 1'b0;
        end while (!r_t);
    endtask
    // no bound here: a hang is cut by the watchdog
    task automatic op(input logic [1:0] k, input logic [15:0] w);
        logic [31:0] s;
        axi_wr(hmp_pkg::CMD_OFF, {14'h0000, k, w});
        do axi_rd(hmp_pkg::STATUS_OFF, s); while (s[0] !== 1'b0);
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic rd_word(input string what, input logic [15:0] exp);
        logic [31:0] s;
        op(hmp_pkg::HMP_READ, 16'h0000);
        axi_rd(hmp_pkg::RDATA_OFF, s);
        check(what, s[15:0], exp);
    endtask
    task automatic core_wr(input logic [13:0] a, input logic [15:0] d);
        caddr <= a;
        cwd <= d;
        we <= 1'b1;
        @(posedge clk_i);
        we <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic give_verdict();
        $display("compares %0d errors %0d", compares, errors);
        if (errors == 0 && compares > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // ----------------------------------------
    // clock, watchdog and tests
    // ----------------------------------------
    initial forever #12.5 clk_i = ~clk_i;
    initial begin
        repeat (20000) @(posedge clk_i);
        errors++;
        give_verdict();
    end
    initial begin
        logic [31:0] s;
        repeat (2) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (4) @(posedge clk_i);
        check("hold", {15'h0000, hold}, 16'h0001);
        op(hmp_pkg::HMP_LATCH, 16'h0010);
        for (int i = 0; i < 3; i++) op(hmp_pkg::HMP_WRITE, 16'h1000 + 16'(i));
        op(hmp_pkg::HMP_LATCH, 16'h0010);
        for (int i = 0; i < 3; i++) rd_word("data", 16'h1000 + 16'(i));
        op(hmp_pkg::HMP_LATCH, 16'h4000);
        op(hmp_pkg::HMP_WRITE, 16'h1234);
        check("hold", {15'h0000, hold}, 16'h0001);
        op(hmp_pkg::HMP_WRITE, 16'h0056);
        check("hold", {15'h0000, hold}, 16'h0000);
        op(hmp_pkg::HMP_LATCH, 16'h4000);
        rd_word("prog_hi", 16'h1234);
        rd_word("prog_lo", 16'h0056);
        op(hmp_pkg::HMP_LATCH, 16'h8000);
        check("ovl", {8'h00, ovl}, 16'h0000);
        check("ctl", crd, 16'h0000);
        op(hmp_pkg::HMP_LATCH, 16'h3fe0);
        op(hmp_pkg::HMP_WRITE, 16'hbeef);
        check("ovl", {8'h00, ovl}, 16'h0000);
        core_wr(hmp_pkg::OVERLAY_ADDR, 16'h0011);
        rd_word("core", 16'h1001);
        core_wr(hmp_pkg::SYSCTL_ADDR, 16'h4000);
        check("sys", crd, 16'h4000);
        op(hmp_pkg::HMP_LATCH, 16'h0010);
        op(hmp_pkg::HMP_LATCH, 16'h8000);
        rd_word("short", 16'h1000);
        rd_word("short", 16'h1001);
        axi_rd(4'hc, s);
        check("unmapped", s[15:0], 16'h0000);
        give_verdict();
    end
endmodule
